// File: src/bstp_pkg.sv
package bstp_pkg;
   // ---------------------------------------------------------------
   // instruction codes and widths
   // ---------------------------------------------------------------
   localparam int IR_W = 3;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INS_PRELOAD = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam int ID_W = 32;
   localparam int BSR_W = 8;
   localparam int RESET_TMS_EDGES = 5;

   // ---------------------------------------------------------------
   // tap controller states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001, ST_IDLE = 16'h0002,
      ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
      ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000,
      ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
   } bstp_state_t;

   // pins of the test port
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bstp_pins_t;

   // whole state of the port
   typedef struct packed {
      bstp_pins_t s1;
      bstp_pins_t s2;
      logic [BSR_W-1:0] pins_s1;
      logic [BSR_W-1:0] pins_s2;
      logic tck_d;
      bstp_state_t st;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic byp;
      logic [ID_W-1:0] id_sh;
      logic [BSR_W-1:0] bsr_sh;
      logic [BSR_W-1:0] bsr_upd;
      logic tdo;
      logic tdo_oe;
   } bstp_regs_t;
endpackage

// File: src/bstp_port.sv
// Overview of operation
// - standard boundary-scan state machine and shifting
// - comes up reset, idle without clock
// - floating pins read high, memory unaffected
// - inputs on rising edge, outputs after falling, except extest_en, outputs_hiz cleared on rise into reset
// - tms sampled rising, steps state machine
// - tdi sampled rising, shifted into selection
// - state and instruction select serial register
// - tdo drives selected register end when shifting
// - five tms-high edges reach reset
// - three-bit instruction, preset to identification
// - capture-ir loads 01 into low bits
// - one-bit bypass register between tdi, tdo
`timescale 1ns/1ps
module bstp_port
   import bstp_pkg::*;
#(
   parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // test pins, pulled up externally when floating
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo_o,
   output logic tdo_oe,
   // boundary cells
   input wire logic [BSR_W-1:0] pins_in,
   output logic [BSR_W-1:0] bsr_out,
   output logic extest_en,
   output logic outputs_hiz
);
   bstp_regs_t r_reg, r_next;
   logic rise, fall;

   // ---------------------------------------------------------------
   // tap state step
   // ---------------------------------------------------------------
   // standard state table
   function automatic bstp_state_t step(bstp_state_t s, logic m);
      case (s)
         ST_RESET: step = m ? ST_RESET : ST_IDLE;
         ST_IDLE: step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: step = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: step = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: step = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: step = m ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR: step = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: step = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: step = m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: step = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: step = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: step = m ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR: step = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: step = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: step = m ? ST_SEL_DR : ST_IDLE;
         default: step = ST_RESET;
      endcase
   endfunction

   function automatic logic uses_bsr(logic [IR_W-1:0] i);
      uses_bsr = (i == INS_EXTEST) || (i == INS_SAMPLE_Z) ||
                 (i == INS_PRELOAD);
   endfunction

   assign rise = r_reg.s2.tck & ~r_reg.tck_d;
   assign fall = ~r_reg.s2.tck & r_reg.tck_d;

   always_comb begin
      r_next = r_reg;
      r_next.s1 = '{tck: tck, tms: tms, tdi: tdi};
      r_next.s2 = r_reg.s1;
      r_next.tck_d = r_reg.s2.tck;
      r_next.pins_s1 = pins_in;
      r_next.pins_s2 = r_reg.pins_s1;
      if (rise) begin
         r_next.st = step(r_reg.st, r_reg.s2.tms);
         case (r_reg.st)
            ST_CAP_IR: r_next.ir_sh = {1'b0, IR_CAPTURE};
            ST_SH_IR: r_next.ir_sh = {r_reg.s2.tdi, r_reg.ir_sh[IR_W-1:1]};
            ST_CAP_DR: begin
               r_next.byp = 1'b0;
               r_next.id_sh = ID_CODE;
               r_next.bsr_sh = r_reg.pins_s2;
            end
            ST_SH_DR: begin
               r_next.byp = r_reg.s2.tdi;
               r_next.id_sh = {r_reg.s2.tdi, r_reg.id_sh[ID_W-1:1]};
               r_next.bsr_sh = {r_reg.s2.tdi, r_reg.bsr_sh[BSR_W-1:1]};
            end
            default: begin
            end
         endcase
         if (step(r_reg.st, r_reg.s2.tms) == ST_RESET) begin
            r_next.ir = INS_IDCODE;
         end
      end
      if (fall) begin
         r_next.tdo_oe = (r_reg.st == ST_SH_IR) || (r_reg.st == ST_SH_DR);
         if (r_reg.st == ST_SH_IR) begin
            r_next.tdo = r_reg.ir_sh[0];
         end else if (r_reg.ir == INS_IDCODE) begin
            r_next.tdo = r_reg.id_sh[0];
         end else if (uses_bsr(r_reg.ir)) begin
            r_next.tdo = r_reg.bsr_sh[0];
         end else begin
            r_next.tdo = r_reg.byp;
         end
         if (r_reg.st == ST_UPD_IR) begin
            r_next.ir = r_reg.ir_sh;
         end
         if (r_reg.st == ST_UPD_DR && uses_bsr(r_reg.ir)) begin
            r_next.bsr_upd = r_reg.bsr_sh;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '{s1: '{tck: 1'b1, tms: 1'b1, tdi: 1'b1},
                    s2: '{tck: 1'b1, tms: 1'b1, tdi: 1'b1},
                    pins_s1: '0, pins_s2: '0,
                    tck_d: 1'b1, st: ST_RESET, ir_sh: '0,
                    ir: INS_IDCODE, byp: 1'b0, id_sh: '0,
                    bsr_sh: '0, bsr_upd: '0, tdo: 1'b0, tdo_oe: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign tdo_o = r_reg.tdo;
   assign tdo_oe = r_reg.tdo_oe;
   assign bsr_out = r_reg.bsr_upd;
   assign extest_en = (r_reg.ir == INS_EXTEST);
   assign outputs_hiz = (r_reg.ir == INS_SAMPLE_Z);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_oe_shift;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(tdo_oe) |-> $past(r_reg.st == ST_SH_IR || r_reg.st == ST_SH_DR);
   endproperty
   a_oe_shift: assert property (p_oe_shift)
      else $error("tdo on off shift");

   property p_oe_fall;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(tdo_oe) |-> $past(fall);
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("oe not at fall");

   property p_st_rise;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(r_reg.st) |-> $past(rise);
   endproperty
   a_st_rise: assert property (p_st_rise)
      else $error("step off rise");

   property p_tlr_ir;
      @(posedge clk_sys) disable iff (!resetn)
      r_reg.st == ST_RESET |-> r_reg.ir == INS_IDCODE;
   endproperty
   a_tlr_ir: assert property (p_tlr_ir)
      else $error("ir not preset");

   property p_cap_ir;
      @(posedge clk_sys) disable iff (!resetn)
      (rise && r_reg.st == ST_CAP_IR) |=> r_reg.ir_sh[1:0] == IR_CAPTURE;
   endproperty
   a_cap_ir: assert property (p_cap_ir)
      else $error("capture-ir bad");

   property p_byp;
      @(posedge clk_sys) disable iff (!resetn)
      (rise && r_reg.st == ST_SH_DR) |=> r_reg.byp == $past(r_reg.s2.tdi);
   endproperty
   a_byp: assert property (p_byp)
      else $error("bypass not shifted");

   property p_tdo_stable;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(tdo_o) |-> $past(fall);
   endproperty
   a_tdo_stable: assert property (p_tdo_stable)
      else $error("tdo moved");

   property p_five;
      @(posedge clk_sys) disable iff (!resetn)
      (rise && r_reg.st == ST_SEL_IR && r_reg.s2.tms) |=> r_reg.st == ST_RESET;
   endproperty
   a_five: assert property (p_five)
      else $error("tms reset path");

   property p_ir_shift;
      @(posedge clk_sys) disable iff (!resetn)
      (rise && r_reg.st == ST_SH_IR) |=>
         r_reg.ir_sh[IR_W-1] == $past(r_reg.s2.tdi);
   endproperty
   a_ir_shift: assert property (p_ir_shift)
      else $error("tdi not shifted into ir");

   property p_ir_upd;
      @(posedge clk_sys) disable iff (!resetn)
      (fall && r_reg.st == ST_UPD_IR) |=> r_reg.ir == $past(r_reg.ir_sh);
   endproperty
   a_ir_upd: assert property (p_ir_upd)
      else $error("ir not updated");

   property p_tdo_ir;
      @(posedge clk_sys) disable iff (!resetn)
      (fall && r_reg.st == ST_SH_IR) |=> tdo_o == $past(r_reg.ir_sh[0]);
   endproperty
   a_tdo_ir: assert property (p_tdo_ir)
      else $error("tdo not ir end");

   property p_oe_off;
      @(posedge clk_sys) disable iff (!resetn)
      (fall && r_reg.st != ST_SH_IR && r_reg.st != ST_SH_DR) |=> !tdo_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("tdo driven off shift");

   property p_bsr_fall;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(bsr_out) |-> $past(fall);
   endproperty
   a_bsr_fall: assert property (p_bsr_fall)
      else $error("boundary update off fall");
endmodule

// File: bench/bstp_jtag_model.sv
`timescale 1ns/1ps
module bstp_jtag_model (
   // system clock, paces the link
   input wire logic clk_sys,
   // test pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe
);
   // ---------------------------------------------------------------
   // scan controller
   // ---------------------------------------------------------------
   initial begin
      // idles high like the pulled-up pin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // change pins low, sample tdo before rise
   task automatic step(input logic m, input logic d, output logic q,
      output logic oe);
      @(negedge clk_sys);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk_sys);
      // released pin reads inverse
      q = tdo_oe ? tdo_o : ~tdo_o;
      oe = tdo_oe;
      tck = 1'b1;
      repeat (3) @(negedge clk_sys);
   endtask
endmodule

// File: bench/boundary_scan_test_port_tb.sv
`timescale 1ns/1ps
module boundary_scan_test_port_tb;
   import bstp_pkg::*;
   localparam logic [ID_W-1:0] ID = 32'h8E3C_A5F1; // arbitrary value
   logic clk_sys, resetn, tck, tms, tdi, tdo_o, tdo_oe, extest_en, hiz;
   logic [BSR_W-1:0] pins_in, bsr_out;
   logic q, oe;
   logic [31:0] d;
   int num_errors = 0;
   int compares = 0;
   bstp_port #(.ID_CODE(ID)) u_bstp_port (.clk_sys(clk_sys),
      .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
      .tdo_oe(tdo_oe), .pins_in(pins_in), .bsr_out(bsr_out),
      .extest_en(extest_en), .outputs_hiz(hiz));
   bstp_jtag_model u_bstp_jtag_model (.clk_sys(clk_sys), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic conclude;
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic st(input logic m);
      u_bstp_jtag_model.step(m, 1'b1, q, oe);
   endtask
   // from idle to shift, n bits lsb first, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] di);
      st(1'b1);
      if (ir) st(1'b1);
      st(1'b0);
      st(1'b0);
      for (int k = 0; k < n; k++) begin
         u_bstp_jtag_model.step(k == n - 1, di[k], d[k], oe);
         check("tdo_oe shift", 1, oe);
      end
      st(1'b1);
      st(1'b0);
      check("tdo_oe idle", 0, oe);
   endtask
   task automatic load_ir(input logic [2:0] ins);
      scan(1'b1, IR_W, {29'h0, ins});
      check("ir capture", IR_CAPTURE, d[1:0]);
   endtask
   task automatic t_reset;
      repeat (20) @(negedge clk_sys);
      check("tdo_oe reset", 0, tdo_oe);
      check("extest reset", 0, extest_en);
      check("hiz reset", 0, hiz);
      st(1'b0);
   endtask
   task automatic t_idcode;
      scan(1'b0, ID_W, 32'hFFFF_FFFF);
      check("idcode", ID, d);
   endtask
   task automatic t_bypass;
      load_ir(INS_BYPASS);
      scan(1'b0, 4, 32'hB);
      check("bypass", 4'h6, d[3:0]);
   endtask
   task automatic t_preload;
      load_ir(INS_PRELOAD);
      pins_in = 8'hA5;
      scan(1'b0, BSR_W, 32'h3C);
      check("bsr capture", 8'hA5, d[7:0]);
      check("bsr update", 8'h3C, bsr_out);
      load_ir(INS_SAMPLE_Z);
      check("hiz", 1, hiz);
   endtask
   task automatic t_tms_reset;
      load_ir(INS_EXTEST);
      check("extest", 1, extest_en);
      st(1'b1);
      st(1'b0);
      st(1'b0);
      repeat (4) st(1'b1);
      repeat (8) @(negedge clk_sys);
      check("four ones", 1, extest_en);
      st(1'b1);
      repeat (8) @(negedge clk_sys);
      check("five ones", 0, extest_en);
   endtask
   initial begin
      resetn = 1'b0;
      pins_in = 8'h00;
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      t_reset();
      t_idcode();
      t_bypass();
      t_preload();
      t_tms_reset();
      conclude();
   end
   initial begin
      #200us;
      num_errors++;
      conclude();
   end
endmodule
